// *** rtl/sls_supervisor.sv ***
// supply and line supervisor sequencing the startup and stage enables
// Operation
// - reduced startup current below inhibit threshold
// - start threshold: startup off, controller on
// - below minimum: stages off, startup on
// - savings mode: regulate supply at threshold
// - savings charging only above turn-on level
// - leaving savings: both paths, fresh start
// - supply overvoltage while flyback runs latches
// - fault disables; restart at start threshold
// - flyback needs line and start threshold
// - line above start: startup on immediately
// - brown-out timer, then drive-disable gating
// - feedforward gain follows line range
// - high line: max on time one third
// - line mode defaults to low line
// - high line after continuous qualification time
// - qualify inhibited until line dips once
// - high-to-low timer returns to low line
// - line absent: sink supply, then drain
// - after drain, low bias at minimum
// - latch cleared by brown-out or reset
`timescale 1ns/1ps
module sls_supervisor
    import sls_pkg::*;
#(
    parameter int BO_CYCLES  = sls_pkg::BROWNOUT_CYCLES,
    parameter int L2H_CYCLES = sls_pkg::LOW_TO_HIGH_CYCLES,
    parameter int H2L_CYCLES = sls_pkg::HIGH_TO_LOW_CYCLES
) (
    input  wire logic ref_clk,         // 50 MHz reference clock
    input  wire logic rst_n,           // async reset, active low
    input  wire logic vcc_inhibit,     // supply above inhibit level
    input  wire logic vcc_on,          // supply at start threshold
    input  wire logic vcc_off,         // supply below minimum
    input  wire logic savings_regulation_threshold,       // supply above savings level
    input  wire logic supply_overvoltage_limit,         // supply above overvoltage
    input  wire logic vcc_reset,       // supply below reset level
    input  wire logic hv_ps,           // hv input above turn-on level
    input  wire logic line_ps,         // line input above turn-on
    input  wire logic bo_start,        // line above brown-out start
    input  wire logic bo_stop,         // line below brown-out stop
    input  wire logic drv_disable,     // line below drive-disable
    input  wire logic line_select,     // line above select level
    input  wire logic line_absent,     // ac line removal detected
    input  wire logic savings_req,     // power savings mode request
    input  wire logic fault_latch,     // latching fault detected
    input  wire logic fault_auto,      // non-latching fault present
    output logic      hv_start_en,     // hv startup path enable
    output logic      line_start_en,   // line startup path enable
    output logic      start_full,      // full startup current level
    output logic      vcc_dis_en,      // supply discharge sink
    output logic      pfc_en,          // correction stage enable
    output logic      flyback_en,      // flyback stage enable
    output logic      high_line,       // line mode, high when set
    output logic      ff_gain_high,    // feedforward gain select
    output logic      ton_third,       // max on time cut to a third
    output logic      low_bias         // low bias current state
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 16;                 // number of flags

    logic [NSYNC-1:0] raw;                     // flags as they arrive
    logic [NSYNC-1:0] sync1;                   // first stage only
    logic [NSYNC-1:0] sync2;                   // usable flags

    assign raw = {vcc_inhibit, vcc_on, vcc_off, savings_regulation_threshold, supply_overvoltage_limit,
                  vcc_reset, hv_ps, line_ps, bo_start, bo_stop,
                  drv_disable, line_select, line_absent, savings_req,
                  fault_latch, fault_auto};

    // comparators switch asynchronously to the reference clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    logic s_inh, s_on, s_off, s_pson, s_ovp, s_rst, s_hv, s_ln;
    logic s_bos, s_bop, s_drv, s_sel, s_abs, s_psm, s_fl, s_fa;
    assign {s_inh, s_on, s_off, s_pson, s_ovp, s_rst, s_hv, s_ln,
            s_bos, s_bop, s_drv, s_sel, s_abs, s_psm, s_fl, s_fa}
           = sync2;

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    logic bo_run;                              // brown-out timer run
    logic bo_exp;                              // brown-out expired
    logic l2h_run;                             // low-to-high run
    logic l2h_exp;                             // low-to-high expired
    logic h2l_run;                             // high-to-low run
    logic h2l_exp;                             // high-to-low expired
    logic l2h_inhibit;                         // qualification blocked
    logic bo_start_d;                          // previous bo_start

    // brown-out timer runs from the stop crossing until recovery
    logic bo_armed;                            // stop was crossed
    assign bo_run  = bo_armed;
    assign l2h_run = !high_line && s_sel && !l2h_inhibit;
    assign h2l_run = high_line && !s_sel;

    sls_timer #(.LENGTH(BO_CYCLES)) u_bo_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .run     (bo_run),
        .expired (bo_exp)
    );

    sls_timer #(.LENGTH(L2H_CYCLES)) u_l2h_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .run     (l2h_run),
        .expired (l2h_exp)
    );

    sls_timer #(.LENGTH(H2L_CYCLES)) u_h2l_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .run     (h2l_run),
        .expired (h2l_exp)
    );

    // ------------------------------------------------------------
    // line mode machine
    // ------------------------------------------------------------
    logic next_high_line;                      // next line mode
    logic next_l2h_inhibit;                    // next inhibit
    logic next_bo_armed;                       // next brown-out arm

    always_comb begin
        next_high_line   = high_line;
        next_l2h_inhibit = l2h_inhibit;
        next_bo_armed    = bo_armed;
        if (!high_line && l2h_exp) begin
            next_high_line = 1'b1;
        end else if (high_line && h2l_exp) begin
            next_high_line   = 1'b0;
            next_l2h_inhibit = 1'b1;
        end
        // one dip below brown-out stop frees the qualification
        if (l2h_inhibit && s_bop) begin
            next_l2h_inhibit = 1'b0;
        end
        if (s_bop) begin
            next_bo_armed = 1'b1;
        end else if (s_bos) begin
            next_bo_armed = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_line   <= 1'b0;
            l2h_inhibit <= 1'b0;
            bo_armed    <= 1'b0;
            bo_start_d  <= 1'b0;
        end else begin
            high_line   <= next_high_line;
            l2h_inhibit <= next_l2h_inhibit;
            bo_armed    <= next_bo_armed;
            bo_start_d  <= s_bos;
        end
    end

    // ------------------------------------------------------------
    // supply state machine
    // ------------------------------------------------------------
    sls_state_e state;                         // supply state
    sls_state_e next_state;                    // next supply state
    logic       bo_rise;                       // line crossed start
    logic       bo_cut;                        // brown-out drive cut
    logic       latch_clr;                     // latch release

    assign bo_rise   = s_bos && !bo_start_d;
    assign bo_cut    = bo_exp && s_drv;
    assign latch_clr = bo_cut || s_rst;

    always_comb begin
        next_state = state;
        unique case (state)
            SLS_CHARGE: begin
                // start needs line present and no remaining fault
                if (s_abs) begin
                    next_state = SLS_DISCHG;
                end else if (s_fl) begin
                    next_state = SLS_LATCHED;
                end else if (s_on && !s_fa) begin
                    next_state = SLS_RUN;
                end
            end
            SLS_RUN: begin
                if (s_abs) begin
                    next_state = SLS_DISCHG;
                end else if (s_fl || (flyback_en && s_ovp)) begin
                    next_state = SLS_LATCHED;
                end else if (s_fa || s_off) begin
                    next_state = SLS_CHARGE;
                end else if (s_psm) begin
                    next_state = SLS_SAVINGS;
                end
            end
            SLS_SAVINGS: begin
                if (s_abs) begin
                    next_state = SLS_DISCHG;
                end else if (!s_psm || s_off) begin
                    next_state = SLS_CHARGE;
                end
            end
            SLS_LATCHED: begin
                if (latch_clr) begin
                    next_state = SLS_CHARGE;
                end
            end
            SLS_DISCHG: begin
                if (s_off) begin
                    next_state = SLS_DRAIN;
                end
            end
            SLS_DRAIN: begin
                // one charge pass empties the filter capacitors
                if (!s_abs && s_bos) begin
                    next_state = SLS_CHARGE;
                end else if (s_on) begin
                    next_state = SLS_LOWBIAS;
                end
            end
            SLS_LOWBIAS: begin
                if (!s_abs && s_bos) begin
                    next_state = SLS_CHARGE;
                end
            end
            default: next_state = SLS_CHARGE;
        endcase
    end

    // ------------------------------------------------------------
    // output decode
    // ------------------------------------------------------------
    logic next_start;                          // next startup enable
    logic next_full;                           // next current level
    logic next_dis;                            // next discharge sink
    logic next_run;                            // next stage enable
    logic next_fly;                            // next flyback enable
    logic next_lowb;                           // next low bias

    always_comb begin
        next_start = 1'b0;
        next_run   = 1'b0;
        next_fly   = 1'b0;
        next_dis   = 1'b0;
        next_lowb  = 1'b0;
        unique case (next_state)
            SLS_CHARGE:  next_start = 1'b1;
            SLS_RUN: begin
                next_run = !bo_cut;
                next_fly = !bo_cut && s_bos;
            end
            SLS_SAVINGS: next_start = !s_pson;
            SLS_LATCHED: next_start = 1'b0;
            SLS_DISCHG:  next_dis   = 1'b1;
            SLS_DRAIN:   next_start = 1'b1;
            SLS_LOWBIAS: next_lowb  = s_off;
            default:     next_start = 1'b1;
        endcase
        // a rising line brings the paths on without waiting
        if (bo_rise && next_state != SLS_RUN) begin
            next_start = 1'b1;
        end
        next_full = s_inh;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= SLS_CHARGE;
            hv_start_en   <= 1'b0;
            line_start_en <= 1'b0;
            start_full    <= 1'b0;
            vcc_dis_en    <= 1'b0;
            pfc_en        <= 1'b0;
            flyback_en    <= 1'b0;
            ff_gain_high  <= 1'b0;
            ton_third     <= 1'b0;
            low_bias      <= 1'b0;
        end else begin
            state         <= next_state;
            // in savings each path needs its own input above turn-on
            hv_start_en   <= next_start &&
                             (next_state != SLS_SAVINGS || s_hv);
            line_start_en <= next_start &&
                             (next_state != SLS_SAVINGS || s_ln);
            start_full    <= next_full;
            vcc_dis_en    <= next_dis;
            pfc_en        <= next_run;
            flyback_en    <= next_fly;
            ff_gain_high  <= next_high_line;
            ton_third     <= next_high_line;
            low_bias      <= next_lowb;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    reduced_level_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !s_inh |=> !start_full
    ) else $error("full current below inhibit");

    start_run_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state == SLS_CHARGE && s_on && !s_fa && !s_fl && !s_abs)
        |=> state == SLS_RUN && !hv_start_en
    ) else $error("no run at start threshold");

    min_supply_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state == SLS_RUN && s_off && !s_abs && !s_fl && !s_ovp)
        |=> !pfc_en && !flyback_en && hv_start_en && line_start_en
    ) else $error("no recharge at minimum");

    ovp_latch_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state == SLS_RUN && flyback_en && s_ovp && !s_abs)
        |=> state == SLS_LATCHED ##1 !pfc_en
    ) else $error("overvoltage did not latch");

    flyback_gate_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        flyback_en |-> $past(s_bos)
    ) else $error("flyback without line");

    line_default_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(high_line) |-> $past(s_sel, 2)
    ) else $error("high line without select");

    low_return_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (high_line && h2l_exp) |=> !high_line && l2h_inhibit
    ) else $error("no return to low line");

    absent_sink_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state == SLS_RUN && s_abs) |=> vcc_dis_en && !pfc_en
    ) else $error("no discharge on line loss");

    qualify_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (l2h_inhibit && !high_line) |=> !high_line
    ) else $error("high line while qualify inhibited");

endmodule : sls_supervisor

// *** rtl/sls_pkg.sv ***
// constants, types and timing counts for the startup line supervisor
package sls_pkg;

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;              // 50 MHz reference

    // ------------------------------------------------------------
    // timer lengths, figures in their own unit
    // ------------------------------------------------------------
    localparam int BROWNOUT_TIME_MS    = 54;        // brown-out timer
    localparam int LOW_TO_HIGH_TIME_US = 300;       // high line qualify
    localparam int HIGH_TO_LOW_TIME_MS = 54;        // low line return

    // least times round up to whole cycles
    localparam int BROWNOUT_CYCLES =
        (BROWNOUT_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_TO_HIGH_CYCLES =
        (LOW_TO_HIGH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_TO_LOW_CYCLES =
        (HIGH_TO_LOW_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counter width that holds every timer above
    localparam int TMR_W = 22;

    // ------------------------------------------------------------
    // supply state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SLS_CHARGE  = 3'b000,   // startup paths charging supply
        SLS_RUN     = 3'b001,   // controller enabled
        SLS_SAVINGS = 3'b010,   // power savings regulation
        SLS_LATCHED = 3'b011,   // latched off, waiting for clear
        SLS_DISCHG  = 3'b100,   // sinking supply, ac line absent
        SLS_DRAIN   = 3'b101,   // startup paths drain filter caps
        SLS_LOWBIAS = 3'b110    // low bias after the drain
    } sls_state_e;

endpackage : sls_pkg

// *** rtl/sls_timer.sv ***
// qualification timer: counts while run is high, flags expiry
`timescale 1ns/1ps
module sls_timer #(
    parameter int LENGTH = 16                  // cycles to expiry
) (
    input  wire logic ref_clk,                 // reference clock
    input  wire logic rst_n,                   // async reset, low
    input  wire logic run,                     // count while high
    output logic      expired                  // length reached
);
    import sls_pkg::*;

    logic [TMR_W-1:0] count;                    // elapsed cycles
    logic [TMR_W-1:0] next_count;               // next elapsed
    logic             next_expired;             // next expiry flag

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    // clearing when run drops makes the qualification continuous
    always_comb begin
        next_count   = '0;
        next_expired = 1'b0;
        if (run) begin
            if (count >= TMR_W'(LENGTH - 1)) begin
                next_count   = count;            // saturate
                next_expired = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= '0;
            expired <= 1'b0;
        end else begin
            count   <= next_count;
            expired <= next_expired;
        end
    end

    // expiry only ever rises after a cycle with run high
    timer_needs_run_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(expired) |-> $past(run)
    ) else $error("timer expired without run");

endmodule : sls_timer

// *** bench/sls_mains_model.sv ***
// comparator model of mains, supply capacitor and startup inputs
`timescale 1ns/1ps
module sls_mains_model #(
    parameter int INHIBIT_MV = 1000,    // inhibit level, plain value
    parameter int RESET_MV   = 3000,    // supply reset level
    parameter int START_V    = 100,     // brown-out start level
    parameter int STOP_V     = 90,      // brown-out stop level
    parameter int SELECT_V   = 250      // line select level
) (
    input  wire logic signed [31:0] supply_mv, // supply voltage in mV
    input  wire logic signed [31:0] line_v,    // line sense peak in V
    output logic vcc_inhibit,           // supply above inhibit
    output logic vcc_on,                // supply at start level
    output logic vcc_off,               // supply below minimum
    output logic savings_regulation_threshold,             // supply above savings level
    output logic supply_overvoltage_limit,               // supply above overvoltage
    output logic vcc_reset,             // supply below reset level
    output logic hv_ps,                 // hv input above turn-on
    output logic line_ps,               // line input above turn-on
    output logic bo_start,              // line above brown-out start
    output logic bo_stop,               // line below brown-out stop
    output logic drv_disable,           // line below drive-disable
    output logic line_select            // line above select level
);
    // --------------------------------------------------------
    // comparators; levels are plain so hysteresis is explicit
    // --------------------------------------------------------
    assign vcc_inhibit = supply_mv > INHIBIT_MV;
    assign vcc_on      = supply_mv >= 17000;    // start threshold
    assign vcc_off     = supply_mv < 8800;      // minimum level
    assign savings_regulation_threshold   = supply_mv > 11000;     // savings level
    assign supply_overvoltage_limit     = supply_mv > 28000;     // overvoltage limit
    assign vcc_reset   = supply_mv < RESET_MV;
    assign hv_ps       = line_v > 30;           // savings turn-on
    assign line_ps     = line_v > 30;           // same rail here
    assign bo_start    = line_v > START_V;
    assign bo_stop     = line_v < STOP_V;
    assign drv_disable = line_v < 30;           // drive-disable level
    assign line_select = line_v > SELECT_V;
endmodule : sls_mains_model

// *** bench/testbench.sv ***
// self-checking bench for the startup line supervisor
`timescale 1ns/1ps
module testbench;
    import sls_pkg::*;
    localparam int L2H = 10;            // short qualify count
    localparam int H2L = 20;            // short return count
    logic ref_clk, rst_n, line_absent, savings_req, fault_latch;
    logic fault_auto;                   // non-latching fault
    int   supply_mv, line_v;            // analog stimulus
    int   errors, n_compared;           // bench counters
    logic vi, von, voff, vps, vovp, vrst, hps, lps, bst, bsp, drv, lsel;
    logic hv_en, ln_en, full, dis, pfc, fly, hl, ffg, ton, lb;

    // --------------------------------------------------------
    // clock, partner and design
    // --------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    sls_mains_model i_mains (.supply_mv(supply_mv), .line_v(line_v),
        .vcc_inhibit(vi), .vcc_on(von), .vcc_off(voff), .savings_regulation_threshold(vps),
        .supply_overvoltage_limit(vovp), .vcc_reset(vrst), .hv_ps(hps), .line_ps(lps),
        .bo_start(bst), .bo_stop(bsp), .drv_disable(drv),
        .line_select(lsel));
    sls_supervisor #(.BO_CYCLES(20), .L2H_CYCLES(L2H), .H2L_CYCLES(H2L))
    i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .vcc_inhibit(vi),
        .vcc_on(von), .vcc_off(voff), .savings_regulation_threshold(vps), .supply_overvoltage_limit(vovp),
        .vcc_reset(vrst), .hv_ps(hps), .line_ps(lps), .bo_start(bst),
        .bo_stop(bsp), .drv_disable(drv), .line_select(lsel),
        .line_absent(line_absent), .savings_req(savings_req),
        .fault_latch(fault_latch), .fault_auto(fault_auto),
        .hv_start_en(hv_en), .line_start_en(ln_en), .start_full(full),
        .vcc_dis_en(dis), .pfc_en(pfc), .flyback_en(fly),
        .high_line(hl), .ff_gain_high(ffg), .ton_third(ton),
        .low_bias(lb));

    // --------------------------------------------------------
    // shared helpers
    // --------------------------------------------------------
    task automatic check(input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : settle
    // bounded wait on line mode; lo is the least legal wait
    task automatic wait_hl(input logic lvl, input int lo);
        int n;
        n = 0;
        while (hl !== lvl && n < 80) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 80) begin
            errors++;
            end_sim();
        end
        check(n >= lo, 1'b1);
    endtask : wait_hl
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_reset;
        check(pfc, 1'b0);
        rst_n = 1'b1;
        settle(5);
        check(full, 1'b0);
        check(hl, 1'b0);
        check(hv_en & ln_en, 1'b1);
        supply_mv = 5000;
        settle(5);
        check(full, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_start;
        supply_mv = 17000;
        settle(5);
        check(pfc & fly, 1'b1);
        check(hv_en | ln_en, 1'b0);
        supply_mv = 12000;
        settle(5);
        check(hv_en | ln_en, 1'b0);
        supply_mv = 8000;
        settle(5);
        check(pfc | fly, 1'b0);
        check(hv_en & ln_en, 1'b1);
        line_v = 50;
        supply_mv = 17000;
        settle(5);
        check(fly, 1'b0);
        line_v = 200;
        settle(5);
        check(fly, 1'b1);
        $display("test start done");
    endtask : t_start
    task automatic t_ovp;
        supply_mv = 29000;
        settle(5);
        check(pfc | fly, 1'b0);
        supply_mv = 17000;
        settle(5);
        check(fly, 1'b0);
        supply_mv = 2000;
        settle(5);
        check(hv_en & ln_en, 1'b1);
        supply_mv = 17000;
        settle(5);
        check(fly, 1'b1);
        $display("test ovp done");
    endtask : t_ovp
    task automatic t_savings;
        savings_req = 1'b1;
        supply_mv = 10000;
        settle(5);
        check(hv_en & ln_en, 1'b1);
        supply_mv = 12000;
        settle(5);
        check(hv_en | ln_en, 1'b0);
        line_v = 20;
        supply_mv = 10000;
        settle(5);
        check(hv_en | ln_en, 1'b0);
        line_v = 200;
        savings_req = 1'b0;
        settle(5);
        check(hv_en & ln_en, 1'b1);
        check(pfc, 1'b0);
        supply_mv = 17000;
        settle(5);
        check(pfc, 1'b1);
        $display("test savings done");
    endtask : t_savings
    task automatic t_fault;
        fault_auto = 1'b1;
        settle(5);
        check(pfc | fly, 1'b0);
        fault_auto = 1'b0;
        settle(5);
        check(pfc & fly, 1'b1);
        line_v = 20;
        settle(10);
        check(pfc, 1'b1);
        settle(20);
        check(pfc, 1'b0);
        line_v = 200;
        fault_latch = 1'b1;
        settle(5);
        fault_latch = 1'b0;
        settle(5);
        check(pfc, 1'b0);
        line_v = 20;
        settle(30);
        line_v = 200;
        settle(5);
        check(pfc & fly, 1'b1);
        $display("test fault done");
    endtask : t_fault
    task automatic t_line;
        line_v = 300;
        wait_hl(1'b1, L2H);
        check(ffg & ton, 1'b1);
        line_v = 200;
        wait_hl(1'b0, H2L);
        check(ffg | ton, 1'b0);
        line_v = 300;
        settle(30);
        check(hl, 1'b0);
        line_v = 50;
        settle(5);
        line_v = 300;
        wait_hl(1'b1, L2H);
        $display("test line done");
    endtask : t_line
    task automatic t_absent;
        line_absent = 1'b1;
        settle(5);
        check(pfc | fly, 1'b0);
        check(dis, 1'b1);
        supply_mv = 8000;
        settle(5);
        check(dis, 1'b0);
        check(hv_en & ln_en, 1'b1);
        supply_mv = 17000;
        settle(5);
        supply_mv = 8000;
        settle(5);
        check(lb, 1'b1);
        $display("test absent done");
    endtask : t_absent

    // --------------------------------------------------------
    // main sequence: reset held four cycles, then each test
    // --------------------------------------------------------
    initial begin
        errors = 0;
        n_compared = 0;
        rst_n = 1'b0;
        supply_mv = 0;
        line_v = 200;
        line_absent = 1'b0;
        savings_req = 1'b0;
        fault_latch = 1'b0;
        fault_auto = 1'b0;
        settle(4);
        t_reset();
        t_start();
        t_ovp();
        t_savings();
        t_fault();
        t_line();
        t_absent();
        end_sim();
    end
endmodule : testbench
